//--- hw/ctto_core.sv
// sequencer and datapath for the transfer, test and addressing group
`timescale 1ns/1ps
module ctto_core (
  // clock, reset, enable
  input  wire logic  core_clk,
  input  wire logic  rst_n,
  input  wire logic  clkEn,
  // program and data memory
  output logic [15:0] memAddr,
  output logic        memRdEn,
  output logic        memWrEn,
  output logic [7:0]  memWrData,
  input  wire logic [7:0] memRdData,
  // architectural state, plus the opcode-cycle strobe
  output logic [7:0]  accOut,
  output logic [7:0]  flagsOut,
  output logic [15:0] idxOut,
  output logic [15:0] spOut,
  output logic [15:0] pcOut,
  output logic        instrStart
);
  ctto_pkg::ctto_state_t stateReg;
  ctto_pkg::ctto_state_t decNext;
  ctto_pkg::ctto_mode_t  modeReg;
  ctto_pkg::ctto_mode_t  decMode;
  ctto_pkg::ctto_mode_t  eaMode;
  ctto_pkg::ctto_kind_t  kindReg;
  ctto_pkg::ctto_kind_t  decKind;
  logic [7:0]  accReg;
  logic [7:0]  ccrReg;
  logic [7:0]  hiReg;
  logic [15:0] idxReg;
  logic [15:0] spReg;
  logic [15:0] pcReg;
  logic [15:0] effAddr;
  logic        doFetch;
  logic        doRead;
  logic        doWrite;
  logic [15:0] reqAddr;
  logic [7:0]  reqData;
  logic        flagUpd;
  logic [7:0]  flagSrc;
  logic        inOp;

  assign inOp = (stateReg == ctto_pkg::ST_OP);

  // decode of the opcode byte, or of the byte after the prefix
  always_comb begin
    decMode = ctto_pkg::MODE_DIR;
    decKind = ctto_pkg::KIND_TEST;
    decNext = ctto_pkg::ST_OP;
    if (stateReg == ctto_pkg::ST_PRE) begin
      case (memRdData)
        ctto_pkg::OP_TEST_IX1: begin
          decMode = ctto_pkg::MODE_SP1;
          decNext = ctto_pkg::ST_OFF;
        end
        ctto_pkg::OP_STORE_IX1: begin
          decMode = ctto_pkg::MODE_SP1;
          decKind = ctto_pkg::KIND_STORE;
          decNext = ctto_pkg::ST_OFF;
        end
        ctto_pkg::OP_STORE_IX2: begin
          decMode = ctto_pkg::MODE_SP2;
          decKind = ctto_pkg::KIND_STORE;
          decNext = ctto_pkg::ST_HI;
        end
        default: decNext = ctto_pkg::ST_OP;
      endcase
    end else begin
      case (memRdData)
        ctto_pkg::OP_SP_TO_IDX,
        ctto_pkg::OP_IDX_TO_SP:  decNext = ctto_pkg::ST_FETCH;
        ctto_pkg::OP_PREFIX:     decNext = ctto_pkg::ST_PRE;
        ctto_pkg::OP_TEST_DIR:   decNext = ctto_pkg::ST_OFF;
        ctto_pkg::OP_TEST_IX1: begin
          decMode = ctto_pkg::MODE_IX1;
          decNext = ctto_pkg::ST_OFF;
        end
        ctto_pkg::OP_TEST_IX: begin
          decMode = ctto_pkg::MODE_IX;
          decNext = ctto_pkg::ST_DATA;
        end
        ctto_pkg::OP_STORE_DIR: begin
          decKind = ctto_pkg::KIND_STORE;
          decNext = ctto_pkg::ST_OFF;
        end
        ctto_pkg::OP_STORE_EXT: begin
          decMode = ctto_pkg::MODE_EXT;
          decKind = ctto_pkg::KIND_STORE;
          decNext = ctto_pkg::ST_HI;
        end
        ctto_pkg::OP_STORE_IX2: begin
          decMode = ctto_pkg::MODE_IX2;
          decKind = ctto_pkg::KIND_STORE;
          decNext = ctto_pkg::ST_HI;
        end
        ctto_pkg::OP_STORE_IX1: begin
          decMode = ctto_pkg::MODE_IX1;
          decKind = ctto_pkg::KIND_STORE;
          decNext = ctto_pkg::ST_OFF;
        end
        ctto_pkg::OP_STORE_IX: begin
          decMode = ctto_pkg::MODE_IX;
          decKind = ctto_pkg::KIND_STORE;
          decNext = ctto_pkg::ST_FETCH;
        end
        ctto_pkg::OP_MOVE_POSTINC: begin
          decKind = ctto_pkg::KIND_MOVE;
          decNext = ctto_pkg::ST_OFF;
        end
        ctto_pkg::OP_BRANCH: begin
          decMode = ctto_pkg::MODE_REL;
          decKind = ctto_pkg::KIND_BRANCH;
          decNext = ctto_pkg::ST_OFF;
        end
        // unknown opcodes pass as one-cycle no-ops
        default: decNext = ctto_pkg::ST_OP;
      endcase
    end
  end

  assign eaMode = inOp ? decMode : modeReg;

  ctto_ea_unit eaUnit (
    .mode   (eaMode),
    .idx    (idxReg),
    .sp     (spReg),
    .pc     (pcReg),
    .hiByte (hiReg),
    .loByte (memRdData),
    .ea     (effAddr)
  );

  // one memory request per cycle; a fetch always reads at pc
  always_comb begin
    doFetch = 1'b0;
    doRead  = 1'b0;
    doWrite = 1'b0;
    reqAddr = effAddr;
    reqData = accReg;
    case (stateReg)
      ctto_pkg::ST_OP: begin
        if (decNext == ctto_pkg::ST_DATA)
          doRead = 1'b1;
        else if (decNext == ctto_pkg::ST_FETCH)
          doWrite = (decKind == ctto_pkg::KIND_STORE);
        else
          doFetch = 1'b1;
      end
      ctto_pkg::ST_OFF: begin
        doWrite = (kindReg == ctto_pkg::KIND_STORE);
        doRead  = (kindReg == ctto_pkg::KIND_TEST) ||
                  (kindReg == ctto_pkg::KIND_MOVE);
      end
      ctto_pkg::ST_DATA: begin
        if (kindReg == ctto_pkg::KIND_MOVE) begin
          doWrite = 1'b1;
          reqAddr = idxReg;
          reqData = memRdData;
        end else begin
          doFetch = 1'b1;
        end
      end
      default: doFetch = 1'b1;
    endcase
    if (doFetch)
      reqAddr = pcReg;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      memAddr   <= 16'h0000;
      memRdEn   <= 1'b0;
      memWrEn   <= 1'b0;
      memWrData <= 8'h00;
    end else if (clkEn) begin
      memAddr   <= reqAddr;
      memRdEn   <= doFetch | doRead;
      memWrEn   <= doWrite;
      memWrData <= reqData;
    end
  end

  // sequencer; reset starts with a fetch so the first opcode arrives in op
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stateReg <= ctto_pkg::ST_FETCH;
    end else if (clkEn) begin
      case (stateReg)
        ctto_pkg::ST_OP,
        ctto_pkg::ST_PRE: stateReg <= decNext;
        ctto_pkg::ST_HI:  stateReg <= ctto_pkg::ST_OFF;
        ctto_pkg::ST_OFF:
          stateReg <= (kindReg == ctto_pkg::KIND_STORE ||
                       kindReg == ctto_pkg::KIND_BRANCH) ?
                      ctto_pkg::ST_FETCH : ctto_pkg::ST_DATA;
        ctto_pkg::ST_DATA:
          stateReg <= (kindReg == ctto_pkg::KIND_MOVE) ?
                      ctto_pkg::ST_FETCH : ctto_pkg::ST_OP;
        default: stateReg <= ctto_pkg::ST_OP;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      modeReg <= ctto_pkg::MODE_DIR;
      kindReg <= ctto_pkg::KIND_TEST;
      hiReg   <= 8'h00;
    end else if (clkEn) begin
      if (inOp || stateReg == ctto_pkg::ST_PRE) begin
        modeReg <= decMode;
        kindReg <= decKind;
      end
      if (stateReg == ctto_pkg::ST_HI)
        hiReg <= memRdData;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      pcReg <= ctto_pkg::PC_RESET;
    else if (clkEn) begin
      if (doFetch)
        pcReg <= pcReg + 16'h0001;
      else if (stateReg == ctto_pkg::ST_OFF &&
               kindReg == ctto_pkg::KIND_BRANCH)
        pcReg <= effAddr;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      accReg <= ctto_pkg::ACC_RESET;
    else if (clkEn && inOp) begin
      if (memRdData == ctto_pkg::OP_FLAGS_TO_ACC)
        accReg <= ccrReg;
      else if (memRdData == ctto_pkg::OP_IDX_TO_ACC)
        accReg <= idxReg[7:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      idxReg <= ctto_pkg::IDX_RESET;
    else if (clkEn) begin
      if (inOp && memRdData == ctto_pkg::OP_SP_TO_IDX)
        idxReg <= spReg + 16'h0001;
      else if (stateReg == ctto_pkg::ST_FETCH &&
               kindReg == ctto_pkg::KIND_MOVE)
        idxReg <= idxReg + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      spReg <= ctto_pkg::SP_RESET;
    else if (clkEn && inOp && memRdData == ctto_pkg::OP_IDX_TO_SP)
      spReg <= idxReg - 16'h0001;
  end

  // tests, stores and moves set N and Z from the byte handled, clear V
  always_comb begin
    flagUpd = 1'b0;
    flagSrc = memRdData;
    if (inOp && memRdData == ctto_pkg::OP_TEST_ACC) begin
      flagUpd = 1'b1;
      flagSrc = accReg;
    end else if (inOp && memRdData == ctto_pkg::OP_TEST_IDX) begin
      flagUpd = 1'b1;
      flagSrc = idxReg[7:0];
    end else if (doWrite && reqData == accReg &&
                 stateReg != ctto_pkg::ST_DATA) begin
      flagUpd = 1'b1;
      flagSrc = accReg;
    end else if (stateReg == ctto_pkg::ST_DATA) begin
      flagUpd = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      ccrReg <= ctto_pkg::CCR_RESET;
    else if (clkEn && flagUpd) begin
      ccrReg[ctto_pkg::FLAG_V] <= 1'b0;
      ccrReg[ctto_pkg::FLAG_N] <= flagSrc[7];
      ccrReg[ctto_pkg::FLAG_Z] <= (flagSrc == 8'h00);
    end
  end

  assign accOut     = accReg;
  assign flagsOut   = ccrReg;
  assign idxOut     = idxReg;
  assign spOut      = spReg;
  assign pcOut      = pcReg;
  assign instrStart = inOp;

  default clocking cb @(posedge core_clk iff clkEn); endclocking
  default disable iff (!rst_n);

  sequence sOpIs(logic [7:0] code);
    inOp && memRdData == code;
  endsequence
  sequence sLongHead(logic [7:0] code);
    sOpIs(code) ##1 stateReg == ctto_pkg::ST_HI ##1
      stateReg == ctto_pkg::ST_OFF;
  endsequence

  a_flags_to_acc: assert property (sOpIs(ctto_pkg::OP_FLAGS_TO_ACC)
    |=> accReg == $past(ccrReg) && ccrReg == $past(ccrReg) && inOp)
    else $error("flag copy to accumulator wrong");
  a_test_acc_flags: assert property (sOpIs(ctto_pkg::OP_TEST_ACC) |=>
    !ccrReg[7] && ccrReg[1] == ($past(accReg) == 8'h00) &&
    ccrReg[2] == $past(accReg[7]) && ccrReg[0] == $past(ccrReg[0]) && inOp)
    else $error("accumulator test flags wrong");
  a_sp_to_idx: assert property (sOpIs(ctto_pkg::OP_SP_TO_IDX) |=>
    idxReg == $past(spReg) + 16'h0001 && ccrReg == $past(ccrReg) ##1 inOp)
    else $error("index pair load from stack pointer wrong");
  a_idx_low_acc: assert property (sOpIs(ctto_pkg::OP_IDX_TO_ACC) |=>
    accReg == $past(idxReg[7:0]) && inOp)
    else $error("index low copy wrong");
  a_idx_to_sp: assert property (sOpIs(ctto_pkg::OP_IDX_TO_SP) |=>
    spReg == $past(idxReg) - 16'h0001 ##1 inOp)
    else $error("stack pointer load from index pair wrong");
  a_long_address: assert property (sLongHead(ctto_pkg::OP_STORE_EXT)
    |=> memWrEn && memAddr == {$past(memRdData, 2), $past(memRdData)})
    else $error("long absolute address wrong");
  a_word_offset: assert property (sLongHead(ctto_pkg::OP_STORE_IX2)
    |=> memWrEn &&
    memAddr == $past(idxReg) + {$past(memRdData, 2), $past(memRdData)})
    else $error("word offset address wrong");
  a_byte_offset: assert property (sOpIs(ctto_pkg::OP_STORE_IX1) ##1
    stateReg == ctto_pkg::ST_OFF |=>
    memWrEn && memAddr == $past(idxReg) + {8'h00, $past(memRdData)})
    else $error("byte offset address wrong");
  a_stack_test: assert property (sOpIs(ctto_pkg::OP_PREFIX) ##1
    stateReg == ctto_pkg::ST_PRE && memRdData == ctto_pkg::OP_TEST_IX1 ##1
    stateReg == ctto_pkg::ST_OFF |=> memRdEn &&
    memAddr == $past(spReg) + {8'h00, $past(memRdData)} ##1 inOp)
    else $error("stack relative test wrong");
  a_page_zero: assert property (sOpIs(ctto_pkg::OP_TEST_DIR) ##1
    stateReg == ctto_pkg::ST_OFF |=>
    memRdEn && memAddr == {8'h00, $past(memRdData)})
    else $error("page zero address wrong");
  a_post_increment: assert property (stateReg == ctto_pkg::ST_DATA &&
    kindReg == ctto_pkg::KIND_MOVE |=> memWrEn && memAddr == $past(idxReg)
    ##1 idxReg == $past(idxReg, 2) + 16'h0001)
    else $error("post increment wrong");
  a_branch_target: assert property (stateReg == ctto_pkg::ST_OFF &&
    kindReg == ctto_pkg::KIND_BRANCH |=> pcReg == $past(pcReg) +
    {{8{$past(memRdData[7])}}, $past(memRdData)})
    else $error("branch target wrong");
endmodule // ctto_core

//--- hw/ctto_ea_unit.sv
// effective address former for every addressing mode of the group
`timescale 1ns/1ps
module ctto_ea_unit (
  // operand sources
  input  wire ctto_pkg::ctto_mode_t mode,
  input  wire logic [15:0]          idx,
  input  wire logic [15:0]          sp,
  input  wire logic [15:0]          pc,
  input  wire logic [7:0]           hiByte,
  input  wire logic [7:0]           loByte,
  // result
  output logic [15:0]               ea
);
  always_comb begin
    case (mode)
      ctto_pkg::MODE_DIR: ea = {8'h00, loByte};
      ctto_pkg::MODE_EXT: ea = {hiByte, loByte};
      ctto_pkg::MODE_IX:  ea = idx;
      ctto_pkg::MODE_IX1: ea = idx + {8'h00, loByte};
      ctto_pkg::MODE_IX2: ea = idx + {hiByte, loByte};
      ctto_pkg::MODE_SP1: ea = sp + {8'h00, loByte};
      ctto_pkg::MODE_SP2: ea = sp + {hiByte, loByte};
      ctto_pkg::MODE_REL: ea = pc + {{8{loByte[7]}}, loByte};
      default:            ea = {8'h00, loByte};
    endcase
  end
endmodule // ctto_ea_unit

//--- inc/ctto_pkg.sv
// shared opcodes, flag positions, reset values and types of the decoder
package ctto_pkg;
  // opcodes, first byte unless noted
  localparam logic [7:0] OP_FLAGS_TO_ACC = 8'h85;
  localparam logic [7:0] OP_TEST_ACC     = 8'h4d;
  localparam logic [7:0] OP_TEST_IDX     = 8'h5d;
  localparam logic [7:0] OP_TEST_DIR     = 8'h3d;
  localparam logic [7:0] OP_TEST_IX1     = 8'h6d;
  localparam logic [7:0] OP_TEST_IX      = 8'h7d;
  localparam logic [7:0] OP_SP_TO_IDX    = 8'h95;
  localparam logic [7:0] OP_IDX_TO_SP    = 8'h94;
  localparam logic [7:0] OP_IDX_TO_ACC   = 8'h9f;
  localparam logic [7:0] OP_PREFIX       = 8'h9e;
  localparam logic [7:0] OP_STORE_DIR    = 8'hb7;
  localparam logic [7:0] OP_STORE_EXT    = 8'hc7;
  localparam logic [7:0] OP_STORE_IX2    = 8'hd7;
  localparam logic [7:0] OP_STORE_IX1    = 8'he7;
  localparam logic [7:0] OP_STORE_IX     = 8'hf7;
  localparam logic [7:0] OP_MOVE_POSTINC = 8'h5e;
  localparam logic [7:0] OP_BRANCH       = 8'h20;
  // flag register bit positions
  localparam int FLAG_V = 7;
  localparam int FLAG_N = 2;
  localparam int FLAG_Z = 1;
  localparam int FLAG_C = 0;
  // reset values
  localparam logic [7:0]  ACC_RESET = 8'h00;
  localparam logic [7:0]  CCR_RESET = 8'h68;
  localparam logic [15:0] IDX_RESET = 16'h0000;
  localparam logic [15:0] SP_RESET  = 16'h00ff;
  localparam logic [15:0] PC_RESET  = 16'h0000;
  // sequencer states, gray along op -> off -> data -> fetch
  typedef enum logic [2:0] {
    ST_OP    = 3'h0,
    ST_OFF   = 3'h1,
    ST_DATA  = 3'h3,
    ST_FETCH = 3'h2,
    ST_PRE   = 3'h6,
    ST_HI    = 3'h7
  } ctto_state_t;
  typedef enum logic [3:0] {
    MODE_DIR = 4'h0,
    MODE_EXT = 4'h1,
    MODE_IX  = 4'h2,
    MODE_IX1 = 4'h3,
    MODE_IX2 = 4'h4,
    MODE_SP1 = 4'h5,
    MODE_SP2 = 4'h6,
    MODE_REL = 4'h7
  } ctto_mode_t;
  typedef enum logic [1:0] {
    KIND_TEST   = 2'h0,
    KIND_STORE  = 2'h1,
    KIND_MOVE   = 2'h2,
    KIND_BRANCH = 2'h3
  } ctto_kind_t;
endpackage

//--- sim/ctto_mem_model.sv
// memory partner answering the core's reads in the same cycle
`timescale 1ns/1ps
module ctto_mem_model (
  // clock and enable
  input  wire logic        core_clk,
  input  wire logic        clkEn,
  // core side
  input  wire logic [15:0] memAddr,
  input  wire logic        memRdEn,
  input  wire logic        memWrEn,
  input  wire logic [7:0]  memWrData,
  output logic [7:0]       memRdData
);
  logic [7:0] mem [0:65535];
  logic [7:0] lastRd = 8'h00;
  // an idle bus shows the inverse of the last byte, never a stale copy
  assign memRdData = memRdEn ? mem[memAddr] : ~lastRd;
  always @(posedge core_clk) begin
    if (clkEn && memRdEn)
      lastRd <= mem[memAddr];
    if (clkEn && memWrEn)
      mem[memAddr] <= memWrData;
  end
endmodule // ctto_mem_model

//--- sim/tb_top.sv
// self-checking bench running random programs of the group
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [7:0]  cyc;
    logic [7:0]  acc;
    logic [7:0]  flag_register;
    logic [15:0] idx;
    logic [15:0] sp;
    logic [15:0] pc;
  } ctto_note_t;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
  } ctto_wr_t;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        clkEn = 1'b0;
  logic [15:0] memAddr;
  logic        memRdEn;
  logic        memWrEn;
  logic [7:0]  memWrData;
  logic [7:0]  memRdData;
  logic [7:0]  accOut;
  logic [7:0]  flagsOut;
  logic [15:0] idxOut;
  logic [15:0] spOut;
  logic [15:0] pcOut;
  logic        instrStart;
  int          bad_count = 0;
  int          comparisons = 0;
  logic [15:0] cycCnt = 16'h0000;
  logic [7:0]  shadow [0:65535];
  logic [7:0]  acc;
  logic [7:0]  flag_register;
  logic [15:0] idx;
  logic [15:0] sp;
  logic [15:0] pc;
  ctto_note_t  noteQ [$];
  ctto_wr_t    wrQ [$];

  ctto_core dut (
    .core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn),
    .memAddr(memAddr), .memRdEn(memRdEn), .memWrEn(memWrEn),
    .memWrData(memWrData), .memRdData(memRdData), .accOut(accOut),
    .flagsOut(flagsOut), .idxOut(idxOut), .spOut(spOut), .pcOut(pcOut),
    .instrStart(instrStart)
  );
  ctto_mem_model mem_u (
    .core_clk(core_clk), .clkEn(clkEn), .memAddr(memAddr),
    .memRdEn(memRdEn), .memWrEn(memWrEn), .memWrData(memWrData),
    .memRdData(memRdData)
  );

  always #10 core_clk = ~core_clk;
  // random stalls: counts below are enabled cycles only
  always @(posedge core_clk) begin
    clkEn <= ($urandom_range(3) != 0);
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic seed(input logic [15:0] a, input logic [7:0] d);
    shadow[a] = d;
    mem_u.mem[a] = d;
  endtask
  task automatic put(input logic [7:0] b);
    seed(pc, b);
    pc = pc + 16'h0001;
  endtask
  // state expected at the next opcode: pc already points past it
  task automatic note(input logic [7:0] c);
    noteQ.push_back('{c, acc, flag_register, idx, sp, pc + 16'h0001});
  endtask
  task automatic nz(input logic [7:0] v);
    flag_register[ctto_pkg::FLAG_V] = 1'b0;
    flag_register[ctto_pkg::FLAG_N] = v[7];
    flag_register[ctto_pkg::FLAG_Z] = (v == 8'h00);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    wrQ.push_back('{a, d});
    shadow[a] = d;
  endtask
  task automatic st(input logic [15:0] a);
    wr(a, acc);
    nz(acc);
  endtask
  task automatic em(input int n, input logic [7:0] b0, input logic [7:0] b1,
                    input logic [7:0] b2, input logic [7:0] b3,
                    input logic [7:0] c);
    logic [7:0] b [4];
    b = '{b0, b1, b2, b3};
    for (int i = 0; i < n; i++)
      put(b[i]);
    note(c);
  endtask

  // program stays below 0080 so page-zero data never hits code
  task automatic build();
    logic [7:0] d;
    logic [7:0] f;
    logic [7:0] v;
    acc = ctto_pkg::ACC_RESET;
    flag_register = ctto_pkg::CCR_RESET;
    idx = ctto_pkg::IDX_RESET;
    sp = ctto_pkg::SP_RESET;
    pc = ctto_pkg::PC_RESET;
    noteQ.delete();
    wrQ.delete();
    for (int a = 0; a < 1024; a++)
      seed(16'(a), 8'($urandom));
    note(8'h00);
    acc = flag_register;
    em(1, ctto_pkg::OP_FLAGS_TO_ACC, 8'h00, 8'h00, 8'h00, 8'd1);
    nz(acc);
    em(1, ctto_pkg::OP_TEST_ACC, 8'h00, 8'h00, 8'h00, 8'd1);
    idx = sp + 16'h0001;
    em(1, ctto_pkg::OP_SP_TO_IDX, 8'h00, 8'h00, 8'h00, 8'd2);
    nz(idx[7:0]);
    em(1, ctto_pkg::OP_TEST_IDX, 8'h00, 8'h00, 8'h00, 8'd1);
    d = 8'h80 | 8'($urandom);
    nz(shadow[{8'h00, d}]);
    em(2, ctto_pkg::OP_TEST_DIR, d, 8'h00, 8'h00, 8'd3);
    f = 8'($urandom);
    nz(shadow[idx + {8'h00, f}]);
    em(2, ctto_pkg::OP_TEST_IX1, f, 8'h00, 8'h00, 8'd3);
    nz(shadow[idx]);
    em(1, ctto_pkg::OP_TEST_IX, 8'h00, 8'h00, 8'h00, 8'd2);
    f = 8'($urandom);
    nz(shadow[sp + {8'h00, f}]);
    em(3, ctto_pkg::OP_PREFIX, ctto_pkg::OP_TEST_IX1, f, 8'h00,
       8'd4);
    acc = flag_register;
    em(1, ctto_pkg::OP_FLAGS_TO_ACC, 8'h00, 8'h00, 8'h00, 8'd1);
    d = 8'h80 | 8'($urandom);
    v = shadow[{8'h00, d}];
    wr(idx, v);
    nz(v);
    idx = idx + 16'h0001;
    em(2, ctto_pkg::OP_MOVE_POSTINC, d, 8'h00, 8'h00, 8'd4);
    acc = idx[7:0];
    em(1, ctto_pkg::OP_IDX_TO_ACC, 8'h00, 8'h00, 8'h00, 8'd1);
    d = 8'h80 | 8'($urandom);
    st({8'h00, d});
    em(2, ctto_pkg::OP_STORE_DIR, d, 8'h00, 8'h00, 8'd3);
    f = 8'($urandom);
    st({8'h03, f});
    em(3, ctto_pkg::OP_STORE_EXT, 8'h03, f, 8'h00, 8'd4);
    f = 8'($urandom);
    st(idx + {8'h02, f});
    em(3, ctto_pkg::OP_STORE_IX2, 8'h02, f, 8'h00, 8'd4);
    f = 8'($urandom);
    st(idx + {8'h00, f});
    em(2, ctto_pkg::OP_STORE_IX1, f, 8'h00, 8'h00, 8'd3);
    st(idx);
    em(1, ctto_pkg::OP_STORE_IX, 8'h00, 8'h00, 8'h00, 8'd2);
    sp = idx - 16'h0001;
    em(1, ctto_pkg::OP_IDX_TO_SP, 8'h00, 8'h00, 8'h00, 8'd2);
    f = 8'($urandom);
    st(sp + {8'h00, f});
    em(3, ctto_pkg::OP_PREFIX, ctto_pkg::OP_STORE_IX1, f, 8'h00,
       8'd4);
    f = 8'($urandom);
    st(sp + {8'h01, f});
    em(4, ctto_pkg::OP_PREFIX, ctto_pkg::OP_STORE_IX2, 8'h01, f,
       8'd5);
    // skipped bytes would clobber the accumulator if executed
    f = 8'($urandom_range(15));
    put(ctto_pkg::OP_BRANCH);
    put(f);
    for (int k = 0; k < int'(f); k++)
      put(ctto_pkg::OP_FLAGS_TO_ACC);
    note(8'd3);
    put(ctto_pkg::OP_BRANCH);
    put(8'hfe);
    pc = pc - 16'h0002;
    note(8'd3);
  endtask

  always @(posedge core_clk) begin
    ctto_note_t n;
    ctto_wr_t   w;
    if (rst_n === 1'b1 && clkEn === 1'b1) begin
      if (instrStart === 1'b1 && noteQ.size() != 0) begin
        n = noteQ.pop_front();
        if (n.cyc != 8'h00)
          chk({8'h00, n.cyc}, cycCnt);
        chk({8'h00, n.acc}, {8'h00, accOut});
        chk({8'h00, n.flag_register}, {8'h00, flagsOut});
        chk(n.idx, idxOut);
        chk(n.sp, spOut);
        chk(n.pc, pcOut);
        cycCnt = 16'h0001;
      end else begin
        cycCnt = cycCnt + 16'h0001;
      end
      if (memWrEn === 1'b1) begin
        w = (wrQ.size() != 0) ? wrQ.pop_front() : 24'hxxxxxx;
        chk(w.addr, memAddr);
        chk({8'h00, w.data}, {8'h00, memWrData});
      end
    end
  end

  initial begin
    int unsigned s;
    s = $urandom(79);
    for (int t = 1; t <= 2; t++) begin
      @(posedge core_clk);
      rst_n <= 1'b0;
      @(posedge core_clk);
      build();
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      for (int k = 0; k < 4000 && (noteQ.size() + wrQ.size()) != 0; k++)
        @(posedge core_clk);
      if (noteQ.size() + wrQ.size() != 0)
        bad_count++;
      $display("test %0d done, %0d notes left", t, noteQ.size());
    end
    end_sim();
  end

  // two short programs need a few hundred cycles; allow far more
  initial begin
    #(20 * 20000);
    bad_count++;
    $display("watchdog expired");
    end_sim();
  end
endmodule // tb_top
